// ---- shared/load_diag_pkg.sv ----
// Package for the load diagnostic register bank: offsets, reset values, field layout, types.
// Assumes an 8-bit register port with byte addresses, as the control bus presents it.
package load_diag_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] ADDR_THRESH12   = 8'h0A;
	localparam logic [7:0] ADDR_THRESH34   = 8'h0B;
	localparam logic [7:0] ADDR_REPORT12   = 8'h0C;
	localparam logic [7:0] ADDR_REPORT34   = 8'h0D;
	localparam logic [7:0] ADDR_LINEOUT    = 8'h0E;
	localparam logic [7:0] ADDR_STATE      = 8'h0F;
	localparam logic [7:0] ADDR_FAULT      = 8'h10;

	// ************************************************************
	// Reset values and field constants
	// ************************************************************
	localparam logic [7:0] RESET_THRESH    = 8'h11;
	localparam logic [7:0] RESET_ZERO      = 8'h00;
	localparam logic [3:0] THRESH_MAX_CODE = 4'h9;
	localparam logic [3:0] THRESH_DEFAULT  = 4'h1;
	localparam logic [7:0] STATE_RESET     = 8'h55;
	localparam int         NUM_CH          = 4;
	localparam int         NIB_W           = 4;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		CH_PLAY  = 2'h0,
		CH_HIZ   = 2'h1,
		CH_MUTE  = 2'h2,
		CH_DCDIAG = 2'h3
	} ch_state_t;

	// One channel's DC diagnostic result nibble, msb first.
	typedef struct packed {
		logic shortToGround;
		logic shortToPower;
		logic openLoad;
		logic shortedLoad;
	} diag_result_t;

	// Register-port request.
	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} reg_req_t;

endpackage

// ---- hdl/thresh_field.sv ----
// One 4-bit shorted-load threshold field with write and clamp of undefined codes.
// Assumes a synchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module thresh_field
	import load_diag_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	// Write side
	input  wire logic             wrStrobe,
	input  wire logic [NIB_W-1:0] wrNibble,
	// Field value and effective code
	output logic      [NIB_W-1:0] stored,
	output logic      [NIB_W-1:0] effective
);

	// Stored field resets to the one ohm code.
	always_ff @(posedge clk) begin
		if (rst) begin
			stored <= THRESH_DEFAULT;
		end else if (clkEn && wrStrobe) begin
			stored <= wrNibble;
		end
	end

	// Codes above the five ohm code act as five ohm.
	always_comb begin
		effective = (stored > THRESH_MAX_CODE) ? THRESH_MAX_CODE : stored;
	end

endmodule

// ---- hdl/diag_nibble.sv ----
// Per-channel capture of DC diagnostic results into a 4-bit report nibble.
// Assumes the measurement engine pulses done with its results.
`timescale 1ns/1ps
module diag_nibble
	import load_diag_pkg::*;
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clkEn,
	// Result from the measurement engine
	input  wire logic         done,
	input  diag_result_t      result,
	// Report nibble
	output diag_result_t      report
);

	// Each completed run replaces the previous result.
	always_ff @(posedge clk) begin
		if (rst) begin
			report <= '0;
		end else if (clkEn && done) begin
			report <= result;
		end
	end

endmodule

// ---- hdl/load_diag_fault_status_regs.sv ----
// Register bank for shorted-load thresholds and load-diagnostic, state and fault reports.
// Assumes a byte-wide register port from the control-bus slave, synchronous to clk.
//
// Operation
// - Four-bit threshold code, half ohm per step.
// - First threshold register: ch1 high, ch2 low.
// - Register 0x0B: ch3 high, ch4 low, reset 0x11.
// - Report 0x0C: ch1 high, ch2 low nibble.
// - Report 0x0D: ch3 high, ch4 low nibble.
// - Short-to-ground bit set when found.
// - Short-to-power bit set when found.
// - Open-load and shorted-load bits report detections.
// - Register 0x0E: line-output bits 3-0, upper zero.
// - Register 0x0F: two-bit states, reset 0x55.
// - State codes: play, high-z, mute, diagnostics.
// - Register 0x10: overcurrent high, DC-fault low.
// - Overcurrent flag reads one when detected.
// - DC fault flag reads one when detected.
`timescale 1ns/1ps
module load_diag_fault_status_regs
	import load_diag_pkg::*;
(
	// Clock, reset and enable
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  clkEn,
	// Register port
	input  reg_req_t                   req,
	output logic      [7:0]            rdData,
	output logic                       rdValid,
	// Diagnostic engine results
	input  wire logic [NUM_CH-1:0]     diagDone,
	input  diag_result_t [NUM_CH-1:0]  diagResult,
	input  wire logic [NUM_CH-1:0]     lineOutDone,
	input  wire logic [NUM_CH-1:0]     lineOutResult,
	input  wire logic                  line_output_diag_enable,
	// Channel state and faults from the power stage
	input  ch_state_t [NUM_CH-1:0]     chState,
	input  wire logic [NUM_CH-1:0]     overcurrentIn,
	input  wire logic [NUM_CH-1:0]     dcFaultIn,
	// Threshold outputs to the diagnostic engine
	output logic [NUM_CH*NIB_W-1:0]    shortThreshold
);

	// ************************************************************
	// Threshold fields
	// ************************************************************
	logic [NIB_W-1:0]       storedNib [NUM_CH];
	logic [NIB_W-1:0]       effNib    [NUM_CH];
	logic [NUM_CH-1:0]      nibWrite;
	logic [NIB_W-1:0]       nibData   [NUM_CH];
	logic [7:0]             thresh12;
	logic [7:0]             thresh34;

	// Channels 1 and 3 take the upper nibble, 2 and 4 the lower.
	always_comb begin
		nibWrite[0] = req.wrEn && (req.addr == ADDR_THRESH12);
		nibWrite[1] = req.wrEn && (req.addr == ADDR_THRESH12);
		nibWrite[2] = req.wrEn && (req.addr == ADDR_THRESH34);
		nibWrite[3] = req.wrEn && (req.addr == ADDR_THRESH34);
		nibData[0]  = req.wrData[7:4];
		nibData[1]  = req.wrData[3:0];
		nibData[2]  = req.wrData[7:4];
		nibData[3]  = req.wrData[3:0];
	end

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gThresh
			thresh_field uField (
				.clk       (clk),
				.rst       (rst),
				.clkEn     (clkEn),
				.wrStrobe  (nibWrite[g]),
				.wrNibble  (nibData[g]),
				.stored    (storedNib[g]),
				.effective (effNib[g])
			);
		end
	endgenerate

	assign thresh12 = {storedNib[0], storedNib[1]};
	assign thresh34 = {storedNib[2], storedNib[3]};

	// Effective thresholds registered toward the engine, channel 1 in the top nibble.
	always_ff @(posedge clk) begin
		if (rst) begin
			shortThreshold <= {NUM_CH{THRESH_DEFAULT}};
		end else if (clkEn) begin
			shortThreshold <= {effNib[0], effNib[1], effNib[2], effNib[3]};
		end
	end

	// ************************************************************
	// Diagnostic report nibbles
	// ************************************************************
	diag_result_t [NUM_CH-1:0] report;

	generate
		for (g = 0; g < NUM_CH; g++) begin : gReport
			diag_nibble uNib (
				.clk    (clk),
				.rst    (rst),
				.clkEn  (clkEn),
				.done   (diagDone[g]),
				.result (diagResult[g]),
				.report (report[g])
			);
		end
	endgenerate

	// ************************************************************
	// Line output, state and fault status
	// ************************************************************
	logic [NUM_CH-1:0] lineOut;
	logic [7:0]        stateReg;
	logic [7:0]        faultReg;

	// Line-output results only land while the host has enabled them.
	always_ff @(posedge clk) begin
		if (rst) begin
			lineOut <= '0;
		end else if (clkEn && line_output_diag_enable) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (lineOutDone[i]) begin
					lineOut[NUM_CH-1-i] <= lineOutResult[i];
				end
			end
		end
	end

	// State report follows the state each channel actually reached.
	always_ff @(posedge clk) begin
		if (rst) begin
			stateReg <= STATE_RESET;
		end else if (clkEn) begin
			stateReg <= {chState[0], chState[1], chState[2], chState[3]};
		end
	end

	// Fault flags mirror the power stage detectors.
	always_ff @(posedge clk) begin
		if (rst) begin
			faultReg <= RESET_ZERO;
		end else if (clkEn) begin
			faultReg[7:4] <= {overcurrentIn[0], overcurrentIn[1],
				overcurrentIn[2], overcurrentIn[3]};
			faultReg[3:0] <= {dcFaultIn[0], dcFaultIn[1], dcFaultIn[2], dcFaultIn[3]};
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	logic [7:0] next_rdData;

	// Read mux; unmapped addresses and reserved bits read zero.
	always_comb begin
		case (req.addr)
			ADDR_THRESH12: next_rdData = thresh12;
			ADDR_THRESH34: next_rdData = thresh34;
			ADDR_REPORT12: next_rdData = {report[0], report[1]};
			ADDR_REPORT34: next_rdData = {report[2], report[3]};
			ADDR_LINEOUT:  next_rdData = {4'h0, lineOut};
			ADDR_STATE:    next_rdData = stateReg;
			ADDR_FAULT:    next_rdData = faultReg;
			default:       next_rdData = RESET_ZERO;
		endcase
	end

	// Read data is registered one cycle after the request.
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData  <= RESET_ZERO;
			rdValid <= 1'b0;
		end else if (clkEn) begin
			rdValid <= req.rdEn;
			if (req.rdEn) begin
				rdData <= next_rdData;
			end
		end
	end

endmodule

// ---- verification/load_diag_chk.sv ----
// Checker on the ports of the load diagnostic register bank, bound at the foot.
// Assumes a one-edge read answer and a one-cycle lag of the status images.
`timescale 1ns/1ps
module load_diag_chk
	import load_diag_pkg::*;
(
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    clkEn,
	// Register port
	input reg_req_t                     req,
	input wire logic [7:0]              rdData,
	input wire logic                    rdValid,
	// Status inputs and threshold output
	input ch_state_t [NUM_CH-1:0]       chState,
	input wire logic [NUM_CH-1:0]       overcurrentIn,
	input wire logic [NUM_CH-1:0]       dcFaultIn,
	input wire logic [NUM_CH*NIB_W-1:0] shortThreshold
);
	logic       rd;
	logic       wr;
	logic [7:0] stateNow;
	logic [7:0] faultNow;
	// Taken requests and the images the bank should present from its live inputs.
	assign rd = clkEn && req.rdEn;
	assign wr = clkEn && req.wrEn;
	assign stateNow = {chState[0], chState[1], chState[2], chState[3]};
	assign faultNow = {overcurrentIn[0], overcurrentIn[1], overcurrentIn[2], overcurrentIn[3],
		dcFaultIn[0], dcFaultIn[1], dcFaultIn[2], dcFaultIn[3]};
	function automatic logic [3:0] clampCode(logic [3:0] c);
		return (c > THRESH_MAX_CODE) ? THRESH_MAX_CODE : c;
	endfunction
	// All checks run on the bank clock and rest while reset is high.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_read_valid: assert property (rd |=> rdValid) else $error("read not answered");
	a_valid_cause: assert property (rdValid && $past(clkEn) |-> $past(rd))
		else $error("stray read valid");
	// A low clock enable freezes every output of the bank for that edge.
	a_freeze_hold: assert property (!clkEn |=> $stable(rdData) && $stable(rdValid)
		&& $stable(shortThreshold)) else $error("state moved while disabled");
	a_state_image: assert property (rd && req.addr == ADDR_STATE && !$past(rst)
		|=> rdData == $past(stateNow, 2)) else $error("state image wrong");
	a_fault_image: assert property (rd && req.addr == ADDR_FAULT && !$past(rst)
		|=> rdData == $past(faultNow, 2)) else $error("fault image wrong");
	a_unmapped_zero: assert property (rd && req.addr > ADDR_FAULT
		|=> rdData == RESET_ZERO) else $error("unmapped read not zero");
	a_line_reserved: assert property (rd && req.addr == ADDR_LINEOUT
		|=> rdData[7:4] == 4'h0) else $error("reserved bits set");
	a_thresh_clamp: assert property ((wr && req.addr == ADDR_THRESH34) ##1 clkEn |=>
		shortThreshold[7:0] == {clampCode($past(req.wrData[7:4], 2)),
		clampCode($past(req.wrData[3:0], 2))}) else $error("threshold output wrong");
	a_thresh_readback: assert property ((wr && req.addr == ADDR_THRESH12) ##2
		(rd && req.addr == ADDR_THRESH12) |=> rdData == $past(req.wrData, 3))
		else $error("threshold readback wrong");
	c_state_read: cover property (rd && req.addr == ADDR_STATE);
	c_thresh_write: cover property (wr && req.addr == ADDR_THRESH34);
	c_fault_read: cover property (rd && req.addr == ADDR_FAULT);
endmodule

bind load_diag_fault_status_regs load_diag_chk u_load_diag_chk (.clk(clk), .rst(rst),
	.clkEn(clkEn), .req(req), .rdData(rdData), .rdValid(rdValid), .chState(chState),
	.overcurrentIn(overcurrentIn), .dcFaultIn(dcFaultIn), .shortThreshold(shortThreshold));

// ---- verification/host_bus_model.sv ----
// Host model on the control bus side, issuing single register reads and writes.
// Assumes the bank answers a read on the same edge that takes it.
`timescale 1ns/1ps
module host_bus_model
	import load_diag_pkg::*;
(
	// Clock
	input wire logic       clk,
	// Register port
	output reg_req_t       req,
	input wire logic [7:0] rdData,
	input wire logic       rdValid
);
	logic [7:0] lastRead;
	initial req = '0;
	// Request held to the taking edge; address and data are scrambled once released.
	task automatic access(input logic isWr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1 req = '{isWr, !isWr, addr, data};
		@(posedge clk);
		#1 lastRead = (rdValid === 1'b1) ? rdData : 8'hXX;
		req = '{1'b0, 1'b0, ~addr, ~data};
	endtask
endmodule

// ---- verification/test_load_diag_fault_status_regs.sv ----
// Self-checking bench of the load diagnostic register bank, driven through the host model.
// Assumes the package constants and the one-cycle status lag of the bank.
`timescale 1ns/1ps
module test_load_diag_fault_status_regs import load_diag_pkg::*;;
	logic                      clk, rst, clkEn, loEn;
	logic [NUM_CH-1:0]         diagDone, loDone, loRes, oc, dc;
	diag_result_t [NUM_CH-1:0] diagRes;
	ch_state_t [NUM_CH-1:0]    chState;
	reg_req_t                  req;
	logic [7:0]                rdData, exp, tmp, loExp;
	logic                      rdValid;
	logic [15:0]               thr;
	int                        errorCnt = 0, checksDone = 0, cycles = 0;
	localparam logic [7:0] RST_TBL [7] = '{RESET_THRESH, RESET_THRESH, RESET_ZERO, RESET_ZERO,
		RESET_ZERO, STATE_RESET, RESET_ZERO};

	load_diag_fault_status_regs u_load_diag_fault_status_regs (.clk(clk), .rst(rst),
		.clkEn(clkEn), .req(req), .rdData(rdData), .rdValid(rdValid), .diagDone(diagDone),
		.diagResult(diagRes), .lineOutDone(loDone), .lineOutResult(loRes),
		.line_output_diag_enable(loEn), .chState(chState), .overcurrentIn(oc),
		.dcFaultIn(dc), .shortThreshold(thr));
	host_bus_model u_host_bus_model (.clk(clk), .req(req), .rdData(rdData), .rdValid(rdValid));

	function automatic logic [3:0] thrExp(logic [3:0] c);
		return (c > 4'h9) ? 4'h9 : c;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checksDone++;
		if (seen !== want) begin
			errorCnt++;
			$display("wrong value at %0t: seen %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		u_host_bus_model.access(1'b0, a, 8'h00);
		check({8'h00, u_host_bus_model.lastRead}, {8'h00, want});
	endtask
	task automatic finishTest;
		$display("errors %0d, checks %0d", errorCnt, checksDone);
		if (errorCnt == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Clock of 25 ns, and a cycle ceiling that cuts a hang short.
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errorCnt++;
			finishTest;
		end
	end
	// Reset, then reset values, thresholds, states, and diagnostic and fault reports.
	initial begin
		{rst, clkEn, loEn, diagDone, loDone, loRes, diagRes, oc, dc, loExp} = {2'b11, 45'h0};
		chState = {NUM_CH{CH_HIZ}};
		void'($urandom(60416));
		repeat (3) @(posedge clk);
		#1 rst = 0;
		foreach (RST_TBL[i]) rd(ADDR_THRESH12 + 8'(i), RST_TBL[i]);
		check(thr, 16'h1111);
		for (int c = 0; c < 16; c++) begin
			exp = {4'(c), 4'(15 - c)};
			tmp = 8'($urandom);
			u_host_bus_model.access(1'b1, ADDR_THRESH12, exp);
			rd(ADDR_THRESH12, exp);
			u_host_bus_model.access(1'b1, ADDR_THRESH34, tmp);
			rd(ADDR_THRESH34, tmp);
			check(thr, {thrExp(exp[7:4]), thrExp(exp[3:0]), thrExp(tmp[7:4]), thrExp(tmp[3:0])});
		end
		// Clock enable low: the write is not taken and every register holds its value.
		clkEn = 0;
		u_host_bus_model.access(1'b1, ADDR_THRESH12, ~exp);
		clkEn = 1;
		rd(ADDR_THRESH12, exp);
		check(thr, {thrExp(exp[7:4]), thrExp(exp[3:0]), thrExp(tmp[7:4]), thrExp(tmp[3:0])});
		rd(8'h40, 8'h00);
		for (int s = 0; s < 4; s++) begin
			for (int i = 0; i < NUM_CH; i++) begin
				chState[i] = ch_state_t'(2'(s + i));
				exp[7-2*i -: 2] = 2'(s + i);
			end
			u_host_bus_model.access(1'b1, ADDR_STATE, ~exp);
			rd(ADDR_STATE, exp);
		end
		for (int n = 0; n < 8; n++) begin
			{oc, dc, diagRes, loRes} = 28'($urandom);
			loEn = n[0];
			@(posedge clk);
			#1 {diagDone, loDone} = 8'hFF;
			@(posedge clk);
			#1 {diagDone, loDone} = 8'h00;
			for (int i = 0; i < NUM_CH; i++) begin
				{exp[7-i], exp[3-i]} = {oc[i], dc[i]};
				if (loEn) loExp[3-i] = loRes[i];
			end
			rd(ADDR_REPORT12, {diagRes[0], diagRes[1]});
			u_host_bus_model.access(1'b1, ADDR_REPORT34, 8'hFF);
			rd(ADDR_REPORT34, {diagRes[2], diagRes[3]});
			u_host_bus_model.access(1'b1, ADDR_FAULT, ~exp);
			rd(ADDR_FAULT, exp);
			rd(ADDR_LINEOUT, loExp);
		end
		finishTest;
	end
endmodule
